// ### rtl/gated_timer_pkg.sv
// shared constants for the gated sixteen bit timer/counter
package gated_timer_pkg;

    // register bus geometry
    localparam int ADDR_W = 12;                    // byte address width
    localparam int DATA_W = 8;                     // register data width

    // register offsets
    localparam logic [11:0] COUNT_LOW_ADDR   = 12'h20c;  // count_low_byte
    localparam logic [11:0] COUNT_HIGH_ADDR  = 12'h20d;  // count_high_byte
    localparam logic [11:0] CONTROL_ADDR     = 12'h20e;  // on, wide access, async, prescale
    localparam logic [11:0] GATE_CTRL_ADDR   = 12'h20f;  // gate enable, polarity, gate value
    localparam logic [11:0] CLOCK_SEL_ADDR   = 12'h210;  // clock source and pin select
    localparam logic [11:0] GATE_SEL_ADDR    = 12'h211;  // gate_source_select
    localparam logic [11:0] STATUS_ADDR      = 12'h212;  // rollover_flag

    // control register fields
    localparam int ON_BIT          = 0;            // counter on
    localparam int WIDE_BIT        = 1;            // wide_access_mode
    localparam int ASYNC_BIT       = 2;            // external input not synchronised
    localparam int PRESCALE_LSB    = 4;            // prescale_ratio low bit
    localparam int PRESCALE_W      = 2;            // prescale_ratio width

    // gate control register fields
    localparam int GATE_VALUE_BIT  = 2;            // read-only current gate active state, after polarity
    localparam int GATE_POL_BIT    = 6;            // gate_polarity
    localparam int GATE_EN_BIT     = 7;            // gate_enable_bit

    // clock select register fields
    localparam int CLK_SRC_LSB     = 0;            // clock source field low bit
    localparam int CLK_SRC_W       = 2;            // clock source field width
    localparam int PIN_SEL_BIT     = 2;            // external_clock_pin_select

    // gate select and status fields
    localparam int GATE_SRC_W      = 2;            // gate_source_select width
    localparam int GATE_SRC_N      = 4;            // number of gate sources
    localparam int ROLLOVER_BIT    = 0;            // rollover_flag position

    // clock source encodings
    localparam logic [1:0] SRC_INSTR = 2'h0;       // instruction cycle (clock / 4)
    localparam logic [1:0] SRC_FULL  = 2'h1;       // full oscillator clock
    localparam logic [1:0] SRC_EXT   = 2'h2;       // external_clock_input pin

    // cycle counts
    localparam int INSTR_DIV       = 4;            // clocks per instruction cycle
    localparam int PRESCALE_CNT_W  = 3;            // prescale counter width (up to 8)

    // reset values
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic [1:0]  FIELD2_RESET    = 2'h0;
    localparam logic [2:0]  PRESCALE_RESET  = 3'h0;

endpackage

// ### rtl/pin_sampler.sv
// three flip-flop input sampler with an agreement filter
`timescale 1ns/1ps
module pin_sampler
(
    input  wire logic clk_in,      // system clock
    input  wire logic resetn_in,   // asynchronous reset, active low
    input  wire logic pin_in,      // input from outside the clock domain
    output logic      fast_out,    // second stage, shortest latency
    output logic      level_out    // level accepted once stages two and three agree
);
    logic stage1_reg;              // metastability catcher, read only by stage two
    logic stage2_reg;              // second stage
    logic stage3_reg;              // third stage
    logic level_reg;               // filtered level

    // shift chain
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // accept a change only when the last two stages agree
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            level_reg <= 1'b0;
        else if (stage2_reg == stage3_reg)
            level_reg <= stage3_reg;
    end

    assign fast_out  = stage2_reg;
    assign level_out = level_reg;
endmodule

// ### rtl/gated_timer.sv
// gated sixteen bit timer/counter with prescaler and wide access buffer
//
// Overview of operation
// - off when on bit clear; gate qualifies counting
// - sixteen bit counter, writes load directly
// - internal clock per instruction cycle, external per edge
// - full oscillator source adds four per instruction
// - falling edge required before first counted rise
// - external rising edges, pin selectable, sync optional
// - prescale 1/2/4/8, hidden, cleared by writes
// - wide mode high write keeps prescaler
// - unsynchronised input keeps counting in sleep
// - sync mode switch may skip or add one
// - byte reads always return a valid value
// - wide mode routes high byte via buffer
// - wide mode low read copies high byte into buffer
// - wide mode: high buffered, low write loads both bytes
// - gate enabled counts only while gate active
// - polarity bit selects active gate level
// - gate source chosen by select field
// - rollover from all ones sets rollover flag
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module gated_timer
(
    input  wire logic                                  clk_in,            // system clock, 10 MHz
    input  wire logic                                  resetn_in,         // asynchronous reset
    input  wire logic [gated_timer_pkg::ADDR_W-1:0]    addr_in,           // register address
    input  wire logic [gated_timer_pkg::DATA_W-1:0]    wdata_in,          // write data
    input  wire logic                                  write_in,          // write strobe
    input  wire logic                                  read_in,           // read strobe
    output logic      [gated_timer_pkg::DATA_W-1:0]    rdata_out,         // read data, next cycle
    input  wire logic [1:0]                            ext_clk_pins_in,   // external_clock_input candidates
    input  wire logic [gated_timer_pkg::GATE_SRC_N-1:0] gate_sources_in,  // gate_signal candidates
    input  wire logic                                  sleep_in,          // device in sleep
    output logic                                       rollover_flag_out, // sticky rollover flag
    output logic [15:0]                                count_out          // live counter_pair value
);
    import gated_timer_pkg::*;

    // software controlled fields
    logic                          on_reg;           // counter on
    logic                          wide_reg;         // wide_access_mode
    logic                          async_reg;        // external input unsynchronised
    logic [PRESCALE_W-1:0]         prescale_ratio;   // prescale_ratio field
    logic                          gate_enable_bit;  // gate_enable_bit
    logic                          gate_polarity;    // gate_polarity
    logic [CLK_SRC_W-1:0]          clk_src_reg;      // clock source selection
    logic                          pin_sel_reg;      // external_clock_pin_select
    logic [GATE_SRC_W-1:0]         gate_source_select; // gate_source_select

    // counting state
    logic [15:0]                   counter_pair;     // live count
    logic [7:0]                    high_buf_reg;     // wide mode high byte buffer
    logic [PRESCALE_CNT_W-1:0]     prescale_reg;     // hidden prescale counter
    logic [1:0]                    instr_div_reg;    // instruction cycle divider
    logic                          ext_prev_reg;     // previous external level
    logic                          armed_reg;        // falling edge seen since last reset of arming
    logic                          rollover_flag;    // sticky rollover flag
    logic [DATA_W-1:0]             rdata_reg;        // registered read data

    // sampled pins
    logic [1:0]                    ext_fast;         // external pins, short path
    logic [1:0]                    ext_level;        // external pins, filtered path
    logic [GATE_SRC_N-1:0]         gate_level;       // gate sources, filtered

    // decoded events
    logic                          wr_low;           // write to count_low_byte
    logic                          wr_high;          // write to count_high_byte
    logic                          rd_low;           // read of count_low_byte
    logic                          ext_now;          // selected external level
    logic                          ext_rise;         // counted rising edge
    logic                          ext_fall;         // falling edge
    logic                          instr_tick;       // one clock per instruction cycle
    logic                          src_tick;         // selected source clock pulse
    logic                          gate_signal;      // selected raw gate level
    logic                          gate_active;      // gate after polarity
    logic                          run;              // counting allowed now
    logic                          awake;            // clock path alive in current power state
    logic                          prescale_done;    // prescaler output pulse
    logic                          count_tick;       // counter increments this cycle
    logic                          prescale_clear;   // prescaler clear request
    logic [PRESCALE_CNT_W-1:0]     prescale_last;    // terminal count of prescaler

    // address match helper shared by writes and reads
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
        hit = (a == target);
    endfunction

    // sample both external clock pins and all gate sources through three flops
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_ext_pin
            pin_sampler u_ext
            (
                .clk_in    (clk_in),
                .resetn_in (resetn_in),
                .pin_in    (ext_clk_pins_in[gi]),
                .fast_out  (ext_fast[gi]),
                .level_out (ext_level[gi])
            );
        end
        for (gi = 0; gi < GATE_SRC_N; gi++)
        begin : g_gate_pin
            pin_sampler u_gate
            (
                .clk_in    (clk_in),
                .resetn_in (resetn_in),
                .pin_in    (gate_sources_in[gi]),
                .fast_out  (),
                .level_out (gate_level[gi])
            );
        end
    endgenerate

    // bus decode
    assign wr_low  = write_in && hit(addr_in, COUNT_LOW_ADDR);
    assign wr_high = write_in && hit(addr_in, COUNT_HIGH_ADDR);
    assign rd_low  = read_in && hit(addr_in, COUNT_LOW_ADDR);

    // pin choice and path choice; the short path models the unsynchronised input
    // and switching paths may drop or add one edge
    assign ext_now  = async_reg ? ext_fast[pin_sel_reg] : ext_level[pin_sel_reg];
    assign ext_rise = ext_now && !ext_prev_reg;
    assign ext_fall = !ext_now && ext_prev_reg;

    // gate source and polarity
    assign gate_signal = gate_level[gate_source_select];
    assign gate_active = gate_polarity ? gate_signal : !gate_signal;

    // on bit and gate decide whether counting may happen
    assign run = on_reg && (!gate_enable_bit || gate_active);

    // in sleep only the unsynchronised external path keeps going
    assign awake = !sleep_in || (async_reg && (clk_src_reg == SRC_EXT));

    assign instr_tick = (instr_div_reg == 2'(INSTR_DIV - 1));

    // source clock pulse selection
    always_comb
    begin
        unique case (clk_src_reg)
            SRC_INSTR: src_tick = instr_tick;
            SRC_FULL:  src_tick = 1'b1;
            SRC_EXT:   src_tick = ext_rise && armed_reg;
            default:   src_tick = 1'b0;                  // reserved code never counts
        endcase
    end

    // prescaler terminal count: ratio 1, 2, 4 or 8; >= lets a lowered ratio act at the next tick
    assign prescale_last  = PRESCALE_CNT_W'((1 << prescale_ratio) - 1);
    assign prescale_done  = src_tick && run && awake && (prescale_reg >= prescale_last);
    assign count_tick     = prescale_done;

    // low write always clears, high write clears only outside wide mode
    assign prescale_clear = wr_low || (wr_high && !wide_reg);

    // instruction cycle divider, free running
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            instr_div_reg <= 2'h0;
        else
            instr_div_reg <= instr_div_reg + 2'h1;
    end

    // external edge history
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            ext_prev_reg <= 1'b0;
        else
            ext_prev_reg <= ext_now;
    end

    // arming: cleared by reset, disabling or count write, set by a falling edge
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            armed_reg <= 1'b0;
        else if (!on_reg || wr_low || wr_high)
            armed_reg <= 1'b0;
        else if (ext_fall)
            armed_reg <= 1'b1;
    end

    // hidden prescale counter; never visible on the bus
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            prescale_reg <= PRESCALE_RESET;
        else if (prescale_clear)
            prescale_reg <= PRESCALE_RESET;
        else if (prescale_done)
            prescale_reg <= PRESCALE_RESET;
        else if (src_tick && run && awake)
            prescale_reg <= prescale_reg + 3'h1;
    end

    // counter pair: software writes take precedence over increments
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            counter_pair <= COUNT_RESET;
        else if (wr_low)
        begin
            // wide mode loads both bytes at once, high from the buffer, low from the write data
            if (wide_reg)
                counter_pair <= {high_buf_reg, wdata_in};
            else
                counter_pair[7:0] <= wdata_in;
        end
        else if (wr_high && !wide_reg)
            counter_pair[15:8] <= wdata_in;
        else if (count_tick)
            counter_pair <= counter_pair + 16'h0001;
        // otherwise the count holds, stopped or gated off
    end

    // high byte buffer for wide access
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            high_buf_reg <= BYTE_RESET;
        else if (wide_reg && wr_high)
            high_buf_reg <= wdata_in;
        else if (wide_reg && rd_low)
            high_buf_reg <= counter_pair[15:8];
    end

    // rollover flag; a rollover in the clearing cycle wins
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rollover_flag <= 1'b0;
        else if (count_tick && (counter_pair == 16'hffff) && !wr_low && !(wr_high && !wide_reg))
            rollover_flag <= 1'b1;
        else if (write_in && hit(addr_in, STATUS_ADDR))
            rollover_flag <= wdata_in[ROLLOVER_BIT];
    end

    // control register
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            on_reg         <= 1'b0;
            wide_reg       <= 1'b0;
            async_reg      <= 1'b0;
            prescale_ratio <= FIELD2_RESET;
        end
        else if (write_in && hit(addr_in, CONTROL_ADDR))
        begin
            on_reg         <= wdata_in[ON_BIT];
            wide_reg       <= wdata_in[WIDE_BIT];
            async_reg      <= wdata_in[ASYNC_BIT];
            prescale_ratio <= wdata_in[PRESCALE_LSB +: PRESCALE_W];
        end
    end

    // gate control register
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            gate_enable_bit <= 1'b0;
            gate_polarity   <= 1'b0;
        end
        else if (write_in && hit(addr_in, GATE_CTRL_ADDR))
        begin
            gate_enable_bit <= wdata_in[GATE_EN_BIT];
            gate_polarity   <= wdata_in[GATE_POL_BIT];
        end
    end

    // clock and gate selection registers
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            clk_src_reg        <= FIELD2_RESET;
            pin_sel_reg        <= 1'b0;
            gate_source_select <= FIELD2_RESET;
        end
        else
        begin
            if (write_in && hit(addr_in, CLOCK_SEL_ADDR))
            begin
                clk_src_reg <= wdata_in[CLK_SRC_LSB +: CLK_SRC_W];
                pin_sel_reg <= wdata_in[PIN_SEL_BIT];
            end
            if (write_in && hit(addr_in, GATE_SEL_ADDR))
                gate_source_select <= wdata_in[GATE_SRC_W-1:0];
        end
    end

    // read data, valid the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rdata_reg <= BYTE_RESET;
        else if (!read_in)
            rdata_reg <= BYTE_RESET;
        else
        begin
            rdata_reg <= BYTE_RESET;
            unique case (addr_in)
                COUNT_LOW_ADDR:
                    rdata_reg <= counter_pair[7:0];
                COUNT_HIGH_ADDR:
                    // wide mode returns the buffered copy
                    rdata_reg <= wide_reg ? high_buf_reg : counter_pair[15:8];
                CONTROL_ADDR:
                begin
                    rdata_reg[ON_BIT]                       <= on_reg;
                    rdata_reg[WIDE_BIT]                     <= wide_reg;
                    rdata_reg[ASYNC_BIT]                    <= async_reg;
                    rdata_reg[PRESCALE_LSB +: PRESCALE_W]   <= prescale_ratio;
                end
                GATE_CTRL_ADDR:
                begin
                    rdata_reg[GATE_EN_BIT]    <= gate_enable_bit;
                    rdata_reg[GATE_POL_BIT]   <= gate_polarity;
                    rdata_reg[GATE_VALUE_BIT] <= gate_active;
                end
                CLOCK_SEL_ADDR:
                begin
                    rdata_reg[CLK_SRC_LSB +: CLK_SRC_W] <= clk_src_reg;
                    rdata_reg[PIN_SEL_BIT]              <= pin_sel_reg;
                end
                GATE_SEL_ADDR:
                    rdata_reg[GATE_SRC_W-1:0] <= gate_source_select;
                STATUS_ADDR:
                    rdata_reg[ROLLOVER_BIT] <= rollover_flag;
                default:
                    rdata_reg <= BYTE_RESET;  // unmapped reads as zero
            endcase
        end
    end

    // outputs
    assign rdata_out         = rdata_reg;
    assign rollover_flag_out = rollover_flag;
    assign count_out         = counter_pair;

endmodule

// ### verif/gated_timer_monitor.sv
// port checker for the gated timer register bus, counter and rollover flag
`timescale 1ns/1ps
module gated_timer_monitor
(
    input  wire logic                               clk_in,            // system clock
    input  wire logic                               resetn_in,         // reset, active low
    input  wire logic [gated_timer_pkg::ADDR_W-1:0] addr_in,           // register address
    input  wire logic [gated_timer_pkg::DATA_W-1:0] wdata_in,          // write data
    input  wire logic                               write_in,          // write strobe
    input  wire logic                               read_in,           // read strobe
    input  wire logic [gated_timer_pkg::DATA_W-1:0] rdata_out,         // read data
    input  wire logic                               rollover_flag_out, // rollover flag
    input  wire logic [15:0]                        count_out          // live count
);
    import gated_timer_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    logic       on_reg;   // shadow of the on bit
    logic       wide_reg; // shadow of wide_access_mode
    logic [7:0] low_byte; // live low count byte
    assign low_byte = count_out[7:0];
    // shadow control bits follow software writes
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            on_reg   <= 1'b0;
            wide_reg <= 1'b0;
        end
        else if (write_in && addr_in == CONTROL_ADDR)
        begin
            on_reg   <= wdata_in[ON_BIT];
            wide_reg <= wdata_in[WIDE_BIT];
        end
    end
    a_read_idle: assert property (!read_in |=> rdata_out == 8'h00) else $error("read data not idle");
    a_low_read: assert property (read_in && addr_in == COUNT_LOW_ADDR |=> rdata_out == $past(low_byte))
        else $error("low byte read wrong");
    a_low_write: assert property (write_in && addr_in == COUNT_LOW_ADDR |=> low_byte == $past(wdata_in))
        else $error("low byte write not loaded");
    a_hold_off: assert property (!on_reg && !write_in |=> $stable(count_out)) else $error("count moved while off");
    a_count_step: assert property (!write_in |=> count_out == $past(count_out) ||
        count_out == $past(count_out) + 16'h1) else $error("count stepped by more than one");
    a_high_buffered: assert property (write_in && addr_in == COUNT_HIGH_ADDR && wide_reg && !on_reg
        |=> $stable(count_out)) else $error("wide high write reached counter");
    a_flag_set: assert property (count_out == 16'hffff && !write_in ##1 count_out == 16'h0000
        |-> rollover_flag_out) else $error("rollover not flagged");
    a_flag_clear: assert property (write_in && addr_in == STATUS_ADDR && !wdata_in[0] && count_out != 16'hffff
        |=> !rollover_flag_out) else $error("flag not cleared");
    a_flag_sticky: assert property (rollover_flag_out && !(write_in && addr_in == STATUS_ADDR)
        |=> rollover_flag_out) else $error("flag dropped");
endmodule
bind gated_timer gated_timer_monitor i_gated_timer_monitor (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
    .rollover_flag_out(rollover_flag_out), .count_out(count_out));

// ### verif/tb_gated_timer.sv
// self-checking bench for the gated sixteen bit timer/counter
`timescale 1ns/1ps
module tb_gated_timer;
    import gated_timer_pkg::*;
    // a row: clock sel, control, gate ctrl, gate sel, gate pins, sleep, window, expected gain
    typedef struct {logic [7:0] cs, ct, gc, gs; logic [3:0] gp; logic sl; int win; logic [15:0] gain;} row_t;
    logic        clk_in, resetn_in, write_in, read_in, sleep_in, rollover_flag_out;
    logic [11:0] addr_in;
    logic [7:0]  wdata_in, rdata_out, rd_val;
    logic [1:0]  ext_clk_pins_in;
    logic [3:0]  gate_sources_in;
    logic [15:0] count_out, c0;
    int          n_mismatch, n_checks;
    row_t        rows [16];
    gated_timer i_gated_timer (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .ext_clk_pins_in(ext_clk_pins_in),
        .gate_sources_in(gate_sources_in), .sleep_in(sleep_in), .rollover_flag_out(rollover_flag_out),
        .count_out(count_out));
    // compare and count
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one-cycle register write
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        @(posedge clk_in);
        write_in <= 1'b0;
    endtask
    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [11:0] a);
        @(posedge clk_in);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge clk_in);
        read_in <= 1'b0;
        @(negedge clk_in);
        rd_val = rdata_out;
    endtask
    // count gained over a window of cycles
    task automatic gain(input int win);
        @(negedge clk_in);
        c0 = count_out;
        repeat (win) @(negedge clk_in);
        c0 = count_out - c0;
    endtask
    // full pulses on external pin one: low then high
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clk_in) ext_clk_pins_in <= 2'b00;
            repeat (8) @(posedge clk_in);
            ext_clk_pins_in <= 2'b10;
            repeat (8) @(posedge clk_in);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // 10 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        stop_test();
    end
    // main sequence
    initial
    begin
        {resetn_in, write_in, read_in, sleep_in, addr_in, wdata_in} = '0;
        ext_clk_pins_in = 2'b00;
        gate_sources_in = 4'h0;
        rows = '{'{8'h01,8'h01,8'h00,8'h00,4'h0,1'b0,16,16'd16}, '{8'h01,8'h11,8'h00,8'h00,4'h0,1'b0,16,16'd8},
            '{8'h01,8'h21,8'h00,8'h00,4'h0,1'b0,16,16'd4}, '{8'h01,8'h31,8'h00,8'h00,4'h0,1'b0,16,16'd2},
            '{8'h00,8'h01,8'h00,8'h00,4'h0,1'b0,64,16'd16}, '{8'h00,8'h11,8'h00,8'h00,4'h0,1'b0,64,16'd8},
            '{8'h00,8'h21,8'h00,8'h00,4'h0,1'b0,64,16'd4}, '{8'h00,8'h31,8'h00,8'h00,4'h0,1'b0,64,16'd2},
            '{8'h01,8'h00,8'h00,8'h00,4'h0,1'b0,16,16'd0}, '{8'h03,8'h01,8'h00,8'h00,4'h0,1'b0,16,16'd0},
            '{8'h00,8'h01,8'h00,8'h00,4'h0,1'b1,64,16'd0}, '{8'h01,8'h01,8'hc0,8'h00,4'h1,1'b0,16,16'd16},
            '{8'h01,8'h01,8'hc0,8'h01,4'hd,1'b0,16,16'd0}, '{8'h01,8'h01,8'h80,8'h02,4'hb,1'b0,16,16'd16},
            '{8'h01,8'h01,8'h80,8'h03,4'h8,1'b0,16,16'd0}, '{8'h01,8'h01,8'h40,8'h00,4'h0,1'b0,16,16'd16}};
        repeat (4) @(posedge clk_in);
        chk("reset_count", 16'h0000, count_out);
        chk("reset_flag", 16'h0000, {15'h0, rollover_flag_out});
        resetn_in <= 1'b1;
        foreach (rows[i])
        begin
            @(posedge clk_in);
            sleep_in <= rows[i].sl;
            gate_sources_in <= rows[i].gp;
            wr(CLOCK_SEL_ADDR, rows[i].cs);
            wr(GATE_SEL_ADDR, rows[i].gs);
            wr(GATE_CTRL_ADDR, rows[i].gc);
            wr(CONTROL_ADDR, rows[i].ct);
            repeat (8) @(posedge clk_in);
            gain(rows[i].win);
            chk("row_gain", rows[i].gain, c0);
        end
        wr(CLOCK_SEL_ADDR, 8'h06);
        wr(COUNT_HIGH_ADDR, 8'h00);
        wr(COUNT_LOW_ADDR, 8'h00);
        ext_clk_pins_in <= 2'b10;
        repeat (8) @(posedge clk_in);
        chk("rise_after_write", 16'h0000, count_out);
        pulses(3);
        chk("sync_edges", 16'h0003, count_out);
        wr(COUNT_LOW_ADDR, 8'h00);
        wr(CONTROL_ADDR, 8'h05);
        sleep_in <= 1'b1;
        pulses(2);
        chk("async_sleep_edges", 16'h0002, count_out);
        sleep_in <= 1'b0;
        wr(CONTROL_ADDR, 8'h00);
        wr(CLOCK_SEL_ADDR, 8'h01);
        wr(COUNT_HIGH_ADDR, 8'h55);
        @(negedge clk_in);
        chk("direct_high", 16'h0055, {8'h00, count_out[15:8]});
        wr(CONTROL_ADDR, 8'h02);
        wr(COUNT_HIGH_ADDR, 8'hab);
        @(negedge clk_in);
        chk("high_buffered", 16'h0055, {8'h00, count_out[15:8]});
        wr(COUNT_LOW_ADDR, 8'hcd);
        @(negedge clk_in);
        chk("wide_load", 16'habcd, count_out);
        rd(COUNT_LOW_ADDR);
        chk("read_low", 16'h00cd, {8'h00, rd_val});
        wr(CONTROL_ADDR, 8'h03);
        wr(COUNT_HIGH_ADDR, 8'h12);
        wr(COUNT_LOW_ADDR, 8'hf0);
        rd(COUNT_LOW_ADDR);
        repeat (30) @(negedge clk_in);
        rd(COUNT_HIGH_ADDR);
        chk("snapshot_high", 16'h0012, {8'h00, rd_val});
        wr(CONTROL_ADDR, 8'h01);
        wr(STATUS_ADDR, 8'h00);
        wr(COUNT_HIGH_ADDR, 8'hff);
        wr(COUNT_LOW_ADDR, 8'hfc);
        repeat (8) @(negedge clk_in);
        chk("rollover_flag", 16'h0001, {15'h0, rollover_flag_out});
        chk("wrapped_high", 16'h0000, {8'h00, count_out[15:8]});
        wr(STATUS_ADDR, 8'h00);
        @(negedge clk_in);
        chk("flag_cleared", 16'h0000, {15'h0, rollover_flag_out});
        rd(12'h0ff);
        chk("unmapped_read", 16'h0000, {8'h00, rd_val});
        @(posedge clk_in);
        resetn_in <= 1'b0;
        @(negedge clk_in);
        chk("midrun_reset", 16'h0000, count_out);
        stop_test();
    end
endmodule
